// >>> design/bridge_ac_excitation_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "excite_consts.svh"
// What this block does
// R1 - Forward phase drives forward output high and reverse output low.
// R2 - Reverse phase drives forward output low and reverse output high.
// R3 - One measurement per phase end; forward and reverse combine into one result.
// R4 - Reference inputs swapped internally during the reverse phase.
// R5 - Drives never overlap; a gap separates release from the next assertion.
// R6 - Polarity toggles once per measurement, locked to the data rate.
// R7 - Chopping needs two phase measurements per result.
// R8 - First chopped result takes twice the normal latency, later ones do not.
// R9 - Later results combine newest measurement with the previous one.
// R10 - Result is forward minus reverse, halved.
// R11 - Each drive has an inverted companion output.
// R12 - Gap lasts a fixed cycle count with all drives off.
module bridge_ac_excitation_sequencer (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic chop_en_i,
   input wire logic conv_done_i,
   input wire excite_pkg::sample_t conv_data_i,
   output logic excite_drive_fwd_o,
   output logic excite_drive_rev_o,
   output logic excite_drive_fwd_n_o,
   output logic excite_drive_rev_n_o,
   output logic ref_swap_o,
   output logic phase_rev_o,
   output logic result_valid_o,
   output excite_pkg::sample_t result_o
);
   import excite_pkg::*;

   // ----------------------------------------
   // State decode helpers
   // ----------------------------------------
   // Forward pair conducts only in the forward phase
   function automatic logic drives_fwd(input excite_state_t s);
      return (s == ST_FWD);
   endfunction : drives_fwd

   // Reverse pair and the reference swap share this window
   function automatic logic drives_rev(input excite_state_t s);
      return (s == ST_REV);
   endfunction : drives_rev

   // A conversion is only paired when it ends inside a drive phase
   function automatic logic in_phase(input excite_state_t s);
      return drives_fwd(s) || drives_rev(s);
   endfunction : in_phase

   // ----------------------------------------
   // Phase sequencer
   // ----------------------------------------
   excite_state_t state_r;
   excite_state_t state_nxt;
   logic next_rev_r;
   logic [7:0] gap_cnt_r;
   logic gap_done;

   assign gap_done = (gap_cnt_r == 8'h01);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (chop_en_i) begin
               state_nxt = ST_GAP;
            end
         end
         ST_FWD, ST_REV: begin
            if (!chop_en_i || conv_done_i) begin
               state_nxt = ST_GAP; // R6
            end
         end
         ST_GAP: begin
            if (!chop_en_i) begin
               state_nxt = ST_IDLE;
            end else if (gap_done) begin
               state_nxt = next_rev_r ? ST_REV : ST_FWD; // R5
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // Polarity memory
   // ----------------------------------------
   // Polarity of the phase to come after the gap
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || state_r == ST_IDLE) begin
         next_rev_r <= 1'b0;
      end else if (state_r == ST_FWD && state_nxt == ST_GAP) begin
         next_rev_r <= 1'b1; // R6
      end else if (state_r == ST_REV && state_nxt == ST_GAP) begin
         next_rev_r <= 1'b0; // R6
      end
   end

   // ----------------------------------------
   // Dead-time counter
   // ----------------------------------------
   // Reloads on every entry, so a cut phase still gets the full gap
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         gap_cnt_r <= `EXCITE_DEAD_CYCLES;
      end else if (state_nxt == ST_GAP && state_r != ST_GAP) begin
         gap_cnt_r <= `EXCITE_DEAD_CYCLES; // R12
      end else if (state_r == ST_GAP && !gap_done) begin
         gap_cnt_r <= gap_cnt_r - 8'h01; // R12
      end
   end

   // ----------------------------------------
   // Drive outputs, registered from the next state
   // ----------------------------------------
   // Driving from state_nxt keeps pins aligned with the state register
   // Forward pair: true output and its companion always move together
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         excite_drive_fwd_o <= 1'b0;
         excite_drive_fwd_n_o <= 1'b1;
      end else begin
         excite_drive_fwd_o <= drives_fwd(state_nxt); // R1
         excite_drive_fwd_n_o <= !drives_fwd(state_nxt); // R11
      end
   end

   // Reverse pair
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         excite_drive_rev_o <= 1'b0;
         excite_drive_rev_n_o <= 1'b1;
      end else begin
         excite_drive_rev_o <= drives_rev(state_nxt); // R2
         excite_drive_rev_n_o <= !drives_rev(state_nxt); // R11
      end
   end

   // Swap window matches the reverse drive exactly, so the reference never goes negative
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ref_swap_o <= 1'b0;
      end else begin
         ref_swap_o <= drives_rev(state_nxt); // R4
      end
   end

   // Polarity flag for the converter's own bookkeeping
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         phase_rev_o <= 1'b0;
      end else begin
         phase_rev_o <= drives_rev(state_nxt);
      end
   end

   // ----------------------------------------
   // Measurement hand-off to the combiner
   // ----------------------------------------
   phase_meas_if meas_if ();
   logic meas_valid_r;
   logic meas_rev_r;
   sample_t meas_data_r;

   // Conversions outside a drive phase carry no valid polarity and are dropped
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         meas_valid_r <= 1'b0;
      end else begin
         meas_valid_r <= conv_done_i && chop_en_i && in_phase(state_r); // R3
      end
   end

   // Polarity tag travels with the sample so the combiner pairs correctly
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         meas_rev_r <= 1'b0;
      end else begin
         meas_rev_r <= drives_rev(state_r);
      end
   end

   // Data captured every cycle; only the valid strobe qualifies it
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         meas_data_r <= '0;
      end else begin
         meas_data_r <= conv_data_i;
      end
   end

   assign meas_if.valid = meas_valid_r;
   assign meas_if.is_rev = meas_rev_r;
   assign meas_if.sample = meas_data_r;

   // Two phases before the first result doubles first latency only
   chop_combiner u_comb ( // R7 R8
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .enable_i(chop_en_i),
      .meas(meas_if.dst),
      .result_valid_o(result_valid_o),
      .result_o(result_o)
   );
endmodule : bridge_ac_excitation_sequencer
`default_nettype wire

// >>> design/chop_combiner.sv
`timescale 1ns/1ps
`default_nettype none
`include "excite_consts.svh"
module chop_combiner (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic enable_i,
   phase_meas_if.dst meas,
   output logic result_valid_o,
   output excite_pkg::sample_t result_o
);
   import excite_pkg::*;
   sample_t fwd_r;
   sample_t rev_r;
   logic have_fwd_r;
   logic have_rev_r;

   // Halved difference kept in 25 bits so it cannot overflow
   function automatic sample_t half_diff(input sample_t a, input sample_t b);
      logic signed [24:0] d;
      d = 25'(signed'(a)) - 25'(signed'(b));
      return sample_t'(d >>> 1);
   endfunction : half_diff

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || !enable_i) begin
         fwd_r <= '0;
         rev_r <= '0;
         have_fwd_r <= 1'b0;
         have_rev_r <= 1'b0;
      end else if (meas.valid) begin
         if (meas.is_rev) begin
            rev_r <= meas.sample;
            have_rev_r <= 1'b1;
         end else begin
            fwd_r <= meas.sample;
            have_fwd_r <= 1'b1;
         end
      end
   end

   // First result only after both phases; then one per measurement
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || !enable_i) begin
         result_valid_o <= 1'b0;
         result_o <= '0;
      end else begin
         result_valid_o <= 1'b0;
         if (meas.valid) begin
            if (meas.is_rev && have_fwd_r) begin
               result_valid_o <= 1'b1; // R3
               result_o <= half_diff(fwd_r, meas.sample); // R10
            end else if (!meas.is_rev && have_rev_r) begin
               result_valid_o <= 1'b1; // R9
               result_o <= half_diff(meas.sample, rev_r); // R10
            end
         end
      end
   end
endmodule : chop_combiner
`default_nettype wire

// >>> design/excite_consts.svh
`ifndef EXCITE_CONSTS_SVH
`define EXCITE_CONSTS_SVH
// Non-overlap gap in core clock cycles
`define EXCITE_DEAD_CYCLES 8'h10
`define EXCITE_DATA_W 24
`endif

// >>> design/excite_pkg.sv
package excite_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_FWD = 4'h2,
      ST_GAP = 4'h4,
      ST_REV = 4'h8
   } excite_state_t;
   typedef logic signed [23:0] sample_t;
endpackage : excite_pkg

// >>> design/phase_meas_if.sv
`timescale 1ns/1ps
`default_nettype none
interface phase_meas_if;
   logic valid;
   logic is_rev;
   excite_pkg::sample_t sample;
   modport src (output valid, output is_rev, output sample);
   modport dst (input valid, input is_rev, input sample);
endinterface : phase_meas_if
`default_nettype wire

// >>> tb/bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_model #(parameter excite_pkg::sample_t offset = 24'h000025) (
   input wire logic clk_i,
   input wire logic fwd_i,
   input wire logic fwd_n_i,
   input wire logic rev_i,
   input wire logic rev_n_i,
   input wire excite_pkg::sample_t sig_i,
   output excite_pkg::sample_t meas_o
);
   import excite_pkg::*;
   // Unexcited bridge floats, so it never reads as a stale value
   sample_t float_r = 24'h5A5A5A;
   always_ff @(posedge clk_i) float_r <= ~float_r;
   always_comb begin
      if (fwd_i && !fwd_n_i && !rev_i) meas_o = sig_i - offset;
      else if (rev_i && !rev_n_i && !fwd_i) meas_o = -sig_i - offset;
      else meas_o = float_r;
   end
endmodule : bridge_model
`default_nettype wire

// >>> tb/excite_chk.sv
`timescale 1ns/1ps
`default_nettype none
module excite_chk (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic chop_en_i,
   input wire logic conv_done_i,
   input wire logic excite_drive_fwd_o,
   input wire logic excite_drive_rev_o,
   input wire logic excite_drive_fwd_n_o,
   input wire logic excite_drive_rev_n_o,
   input wire logic ref_swap_o,
   input wire logic phase_rev_o,
   input wire logic result_valid_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // ----
   // Drives and results
   // ----
   chk_no_overlap: assert property (!(excite_drive_fwd_o && excite_drive_rev_o))
      else $error("overlap");
   chk_fwd_comp: assert property (excite_drive_fwd_n_o != excite_drive_fwd_o)
      else $error("fwd companion");
   chk_rev_comp: assert property (excite_drive_rev_n_o != excite_drive_rev_o)
      else $error("rev companion");
   chk_ref_swap: assert property (ref_swap_o == excite_drive_rev_o && phase_rev_o == ref_swap_o)
      else $error("swap");
   chk_phase_end: assert property (conv_done_i && chop_en_i &&
      (excite_drive_fwd_o || excite_drive_rev_o) |=> !excite_drive_fwd_o && !excite_drive_rev_o)
      else $error("phase end");
   // Gap of 16 follows the dead-time macro
   // Disabling chopping mid-gap legally leaves both drives off
   chk_gap_rev: assert property (disable iff (!resetn_i || !chop_en_i)
      $fell(excite_drive_fwd_o) && chop_en_i |-> ##16 $rose(excite_drive_rev_o))
      else $error("gap to rev");
   chk_gap_fwd: assert property (disable iff (!resetn_i || !chop_en_i)
      $fell(excite_drive_rev_o) && chop_en_i |-> ##16 $rose(excite_drive_fwd_o))
      else $error("gap to fwd");
   chk_pair_lat: assert property (conv_done_i && chop_en_i && excite_drive_rev_o
      |-> ##2 result_valid_o) else $error("pair latency");
   chk_valid_cause: assert property (result_valid_o |-> $past(conv_done_i, 2))
      else $error("valid cause");
endmodule : excite_chk
bind bridge_ac_excitation_sequencer excite_chk chk_i (.core_clk_i, .resetn_i, .chop_en_i,
   .conv_done_i, .excite_drive_fwd_o, .excite_drive_rev_o, .excite_drive_fwd_n_o,
   .excite_drive_rev_n_o, .ref_swap_o, .phase_rev_o, .result_valid_o);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import excite_pkg::*;
   localparam sample_t ofs = 24'h000025;
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic chop_en_i = 1'b0;
   logic conv_done_i = 1'b0;
   sample_t conv_data_i = '0;
   sample_t sig = '0;
   sample_t meas, result_o, last_f, last_r;
   logic fwd, rev, fwd_n, rev_n, swap, prev, valid;
   logic have_r = 1'b0;
   logic is_rev = 1'b0;
   logic [31:0] seed = 32'h0000E58D;
   logic signed [24:0] diff;
   sample_t expq[$];
   int fails = 0;
   int check_count = 0;
   bridge_ac_excitation_sequencer dut (.core_clk_i, .resetn_i, .chop_en_i, .conv_done_i,
      .conv_data_i, .excite_drive_fwd_o(fwd), .excite_drive_rev_o(rev),
      .excite_drive_fwd_n_o(fwd_n), .excite_drive_rev_n_o(rev_n), .ref_swap_o(swap),
      .phase_rev_o(prev), .result_valid_o(valid), .result_o);
   bridge_model #(.offset(ofs)) bridge (.clk_i(core_clk_i), .fwd_i(fwd), .fwd_n_i(fwd_n),
      .rev_i(rev), .rev_n_i(rev_n), .sig_i(sig), .meas_o(meas));
   initial forever #4 core_clk_i = ~core_clk_i;
   // ----
   // Helpers
   // ----
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (exp !== got) begin
         fails++;
         $display("ERROR %s exp %h got %h", what, exp, got);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task automatic measure(input logic poke);
      logic [5:0] exp_pins;
      for (int n = 0; n < 60 && (is_rev ? rev : fwd) !== 1'b1; n++) @(negedge core_clk_i);
      exp_pins = {is_rev, !is_rev, is_rev, is_rev, is_rev, !is_rev};
      check("phase", 24'(exp_pins), 24'({rev, fwd, swap, prev, fwd_n, rev_n}));
      seed = lfsr(seed);
      @(posedge core_clk_i) sig <= sample_t'(signed'(seed[15:0]));
      repeat (seed[17:16]) @(posedge core_clk_i);
      @(posedge core_clk_i) begin
         conv_done_i <= 1'b1;
         conv_data_i <= meas;
      end
      // Noted before the result can appear, even when a poke follows
      if (is_rev) last_r = -sig - ofs;
      else last_f = sig - ofs;
      if (is_rev || have_r) begin
         diff = 25'(last_f) - 25'(last_r);
         expq.push_back(diff[24:1]);
      end
      have_r = have_r | is_rev;
      is_rev = !is_rev;
      @(posedge core_clk_i) conv_done_i <= 1'b0;
      if (poke) begin
         // Lands in the gap and must be dropped
         repeat (2) @(posedge core_clk_i);
         conv_done_i <= 1'b1;
         @(posedge core_clk_i) conv_done_i <= 1'b0;
      end
   endtask : measure
   // ----
   // Sequence
   // ----
   always @(posedge core_clk_i) begin
      if (valid === 1'b1) begin
         if (expq.size() == 0) check("extra result", 24'h0, 24'h1);
         else check("result", expq.pop_front(), result_o);
      end
   end
   initial begin
      #20000;
      fails++;
      stop_test();
   end
   initial begin
      repeat (4) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      @(posedge core_clk_i) chop_en_i <= 1'b1;
      for (int i = 0; i < 6; i++) measure(i == 2);
      // Cut a live forward phase rather than an idle gap
      for (int n = 0; n < 60 && fwd !== 1'b1; n++) @(negedge core_clk_i);
      @(posedge core_clk_i) chop_en_i <= 1'b0;
      repeat (3) @(negedge core_clk_i);
      check("drives off", 24'h3, 24'({fwd, rev, swap, prev, fwd_n, rev_n}));
      @(posedge core_clk_i) chop_en_i <= 1'b1;
      have_r = 1'b0;
      is_rev = 1'b0;
      for (int i = 0; i < 3; i++) measure(1'b0);
      repeat (4) @(posedge core_clk_i);
      check("pending", 24'h0, 24'(expq.size()));
      stop_test();
   end
endmodule : testbench
`default_nettype wire
